// file: rtl/pci_pkg.sv
// parallel capture interface: register map, field layout, bus carriers
// assumes a 32-bit AXI4-Lite slave port with byte addresses of ADDR_W bits
package pci_pkg;

    localparam int unsigned ADDR_W = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_MODE     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_DIS  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_HOLD     = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_WP_MODE  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_WP_STAT  = 8'h1C;

    // capture_mode_reg fields
    localparam int unsigned MODE_EN_BIT    = 0;
    localparam int unsigned MODE_WIDTH_LSB = 4;
    localparam int unsigned MODE_IGN_BIT   = 9;
    localparam int unsigned MODE_HALF_BIT  = 10;
    localparam int unsigned MODE_ODD_BIT   = 11;

    // status / mask bit positions
    localparam int unsigned ST_READY = 0;
    localparam int unsigned ST_OVR   = 1;
    localparam int unsigned ST_END   = 2;
    localparam int unsigned ST_FULL  = 3;
    localparam int unsigned ST_W     = 4;

    // wprot_status_reg: flag in bit 0, source offset from bit 8
    localparam int unsigned WP_SRC_LSB = 8;

    // sample width codes: 8, 16, 32 bits
    localparam logic [1:0] WIDTH_8  = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [ST_W-1:0] MASK_RST = 4'h0;
    localparam int unsigned     SYNC_STAGES = 2;

    typedef struct packed {
        logic       odd_first_sel;
        logic       half_sampling;
        logic       ignore_enables;
        logic [1:0] sample_width_sel;
        logic       capture_enable;
    } pci_mode_s;

    localparam pci_mode_s MODE_RST = '0;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic              awvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              wvalid;
        logic              bready;
        logic [ADDR_W-1:0] araddr;
        logic              arvalid;
        logic              rready;
    } pci_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } pci_axi_rsp_s;

endpackage : pci_pkg

// file: rtl/pci_sync.sv
// two-stage synchroniser for a group of slow pin levels
// assumes each bit is a level held long against clk_i
`timescale 1ns/1ps
`default_nettype none
module pci_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] d_i,
    output var  logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule : pci_sync
`default_nettype wire

// file: rtl/pci_capture_top.sv
// parallel capture interface with AXI4-Lite register slave
// assumes sensor pins asynchronous to clk_i, DMA status levels on clk_i
//
// Contract
// - setting capture enable forces the clock, data and enable pins to inputs
// - while enabled sample data on sensor clock rising edge, resync to clk_i
// - widths over 8 bits concatenate consecutive accepted samples into one word
// - storing a word into the holding register sets data-ready
// - serve a DMA receive channel and show its end and full status
// - enables honoured: sample only when both data enables are high
// - enables ignored: every rising sensor clock edge gives a sample
// - half sampling keeps only every second qualifying sample
// - half sampling index from zero; odd-first picks odd indices, else even
// - storing over an unread word loses it and sets overrun
// - reading the status register clears overrun
// - four status flags raise the interrupt through the enable/disable mask
// - write protect blocks writes to the mode register only
// - blocked write sets violation and records the target register
// - reading write-protect status clears the violation flag
`timescale 1ns/1ps
`default_nettype none
module pci_capture_top (
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire pci_pkg::pci_axi_req_s axi_i,
    output var  pci_pkg::pci_axi_rsp_s axi_o,
    input  wire logic                 sensor_clk_in_i,
    input  wire logic [7:0]           sensor_data_in_i,
    input  wire logic                 data_valid_in_a_i,
    input  wire logic                 data_valid_in_b_i,
    output var  logic                 pin_input_force_o,
    input  wire logic                 rx_transfer_end_i,
    input  wire logic                 rx_buffers_full_i,
    output var  logic                 dma_rx_req_o,
    output var  logic [31:0]          dma_rx_data_o,
    input  wire logic                 dma_rx_ack_i,
    output var  logic                 irq_o
);
    import pci_pkg::*;

    // strobe-merge of a written word into an old one
    function automatic logic [31:0] merge_strb(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_strb

    // index of the last byte of a word for a width code
    function automatic logic [1:0] last_byte(input logic [1:0] sel);
        logic [1:0] res;
        case (sel)
            WIDTH_8:  res = 2'h0;
            WIDTH_16: res = 2'h1;
            default:  res = 2'h3;
        endcase
        return res;
    endfunction : last_byte

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation and sensor clock edge detection
    logic [10:0] pin_s;
    logic        sclk_prev_q;
    logic        sclk_rise;
    logic        en_a_s;
    logic        en_b_s;
    logic [7:0]  data_s;

    pci_sync #(.WIDTH(11)) u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     ({sensor_clk_in_i, data_valid_in_a_i, data_valid_in_b_i, sensor_data_in_i}),
        .q_o     (pin_s)
    );

    assign en_a_s    = pin_s[9];
    assign en_b_s    = pin_s[8];
    assign data_s    = pin_s[7:0];
    assign sclk_rise = pin_s[10] & ~sclk_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // state
    pci_mode_s          mode_q, mode_d;
    logic [ST_W-1:0]    mask_q, mask_d;
    logic               wprot_enable_q, wprot_enable_d;
    logic               wprot_violation_q, wprot_violation_d;
    logic [ADDR_W-1:0]  wpsrc_q, wpsrc_d;
    logic [1:0]         cnt_q, cnt_d;
    logic               idx_q, idx_d;
    logic [31:0]        pack_q, pack_d;
    logic [31:0]        hold_q, hold_d;
    logic               ready_q, ready_d;
    logic               ovr_q, ovr_d;
    logic               awr_q, awr_d;
    logic               bvalid_q, bvalid_d;
    logic [1:0]         bresp_q, bresp_d;
    logic               arr_q, arr_d;
    logic               rvalid_q, rvalid_d;
    logic [1:0]         rresp_q, rresp_d;
    logic [31:0]        rdata_q, rdata_d;
    logic               irq_q, irq_d;

    logic               wr_go;
    logic               rd_go;
    logic               rd_status;
    logic               rd_hold;
    logic               rd_wpstat;
    logic [ST_W-1:0]    status;
    logic               qual;
    logic               keep;
    logic               store;
    logic               consumed;
    logic [31:0]        word;

    assign wr_go     = awr_q & axi_i.awvalid & axi_i.wvalid;
    assign rd_go     = arr_q & axi_i.arvalid;
    assign rd_status = rd_go && axi_i.araddr == OFS_STATUS;
    assign rd_hold   = rd_go && axi_i.araddr == OFS_HOLD;
    assign rd_wpstat = rd_go && axi_i.araddr == OFS_WP_STAT;
    assign status    = {rx_buffers_full_i, rx_transfer_end_i, ovr_q, ready_q};

    ////////////////////////////////////////////////////////////////////////
    // capture: qualify, decimate, pack, store
    always_comb
    begin
        cnt_d    = cnt_q;
        idx_d    = idx_q;
        pack_d   = pack_q;
        hold_d   = hold_q;
        ready_d  = ready_q;
        ovr_d    = ovr_q;
        store    = 1'b0;
        word     = pack_q;
        qual     = sclk_rise && mode_q.capture_enable
                   && (mode_q.ignore_enables || (en_a_s && en_b_s));
        keep     = qual && (!mode_q.half_sampling
                   || idx_q == mode_q.odd_first_sel);
        consumed = rd_hold || (dma_rx_ack_i && ready_q);
        word[{cnt_q, 3'b000} +: 8] = data_s;
        if (qual)
        begin
            idx_d = ~idx_q;
        end
        if (keep)
        begin
            if (cnt_q == last_byte(mode_q.sample_width_sel))
            begin
                store  = 1'b1;
                cnt_d  = 2'h0;
                pack_d = '0;
            end
            else
            begin
                cnt_d  = cnt_q + 2'h1;
                pack_d = word;
            end
        end
        // disabling restarts word and index
        if (!mode_q.capture_enable)
        begin
            cnt_d  = 2'h0;
            idx_d  = 1'b0;
            pack_d = '0;
        end
        if (consumed)
        begin
            ready_d = 1'b0;
        end
        if (rd_status)
        begin
            ovr_d = 1'b0;
        end
        // store wins over a same-cycle read or clear
        if (store)
        begin
            hold_d  = word;
            ready_d = 1'b1;
            if (ready_q && !consumed)
            begin
                ovr_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sclk_prev_q <= 1'b0;
            cnt_q       <= 2'h0;
            idx_q       <= 1'b0;
            pack_q      <= '0;
            hold_q      <= '0;
            ready_q     <= 1'b0;
            ovr_q       <= 1'b0;
        end
        else
        begin
            sclk_prev_q <= pin_s[10];
            cnt_q       <= cnt_d;
            idx_q       <= idx_d;
            pack_q      <= pack_d;
            hold_q      <= hold_d;
            ready_q     <= ready_d;
            ovr_q       <= ovr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register slave: handshakes, writes, reads, write protection
    always_comb
    begin
        logic [31:0] mw;
        mw       = '0;
        mode_d   = mode_q;
        mask_d   = mask_q;
        wprot_enable_d   = wprot_enable_q;
        wprot_violation_d   = wprot_violation_q;
        wpsrc_d  = wpsrc_q;
        awr_d    = 1'b0;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        arr_d    = 1'b0;
        rvalid_d = rvalid_q;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        irq_d    = |(status & mask_q);

        // write channel: ready for one cycle once both halves are offered
        if (!awr_q && !bvalid_q && axi_i.awvalid && axi_i.wvalid)
        begin
            awr_d = 1'b1;
        end
        if (bvalid_q && axi_i.bready)
        begin
            bvalid_d = 1'b0;
        end
        if (rd_wpstat)
        begin
            wprot_violation_d = 1'b0;
        end
        if (wr_go)
        begin
            bvalid_d = 1'b1;
            bresp_d  = RESP_OKAY;
            case (axi_i.awaddr)
                OFS_MODE:
                begin
                    if (wprot_enable_q)
                    begin
                        wprot_violation_d  = 1'b1;
                        wpsrc_d = axi_i.awaddr;
                    end
                    else
                    begin
                        mw = merge_strb({20'h0, mode_q.odd_first_sel, mode_q.half_sampling,
                                         mode_q.ignore_enables, 3'h0,
                                         mode_q.sample_width_sel, 3'h0,
                                         mode_q.capture_enable},
                                        axi_i.wdata, axi_i.wstrb);
                        mode_d.capture_enable   = mw[MODE_EN_BIT];
                        mode_d.sample_width_sel = mw[MODE_WIDTH_LSB +: 2];
                        mode_d.ignore_enables   = mw[MODE_IGN_BIT];
                        mode_d.half_sampling    = mw[MODE_HALF_BIT];
                        mode_d.odd_first_sel    = mw[MODE_ODD_BIT];
                    end
                end
                OFS_IRQ_EN:
                begin
                    if (axi_i.wstrb[0])
                    begin
                        mask_d = mask_q | axi_i.wdata[ST_W-1:0];
                    end
                end
                OFS_IRQ_DIS:
                begin
                    if (axi_i.wstrb[0])
                    begin
                        mask_d = mask_q & ~axi_i.wdata[ST_W-1:0];
                    end
                end
                OFS_WP_MODE:
                begin
                    if (axi_i.wstrb[0])
                    begin
                        wprot_enable_d = axi_i.wdata[0];
                    end
                end
                OFS_IRQ_MASK, OFS_STATUS, OFS_HOLD, OFS_WP_STAT: bresp_d = RESP_OKAY;
                default: bresp_d = RESP_SLVERR;
            endcase
        end

        // read channel: one-cycle ready, data registered
        if (!arr_q && !rvalid_q && axi_i.arvalid)
        begin
            arr_d = 1'b1;
        end
        if (rvalid_q && axi_i.rready)
        begin
            rvalid_d = 1'b0;
        end
        if (rd_go)
        begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            rdata_d  = '0;
            case (axi_i.araddr)
                OFS_MODE:
                begin
                    rdata_d[MODE_EN_BIT]           = mode_q.capture_enable;
                    rdata_d[MODE_WIDTH_LSB +: 2]   = mode_q.sample_width_sel;
                    rdata_d[MODE_IGN_BIT]          = mode_q.ignore_enables;
                    rdata_d[MODE_HALF_BIT]         = mode_q.half_sampling;
                    rdata_d[MODE_ODD_BIT]          = mode_q.odd_first_sel;
                end
                OFS_IRQ_MASK: rdata_d[ST_W-1:0] = mask_q;
                OFS_STATUS:   rdata_d[ST_W-1:0] = status;
                OFS_HOLD:     rdata_d = hold_q;
                OFS_WP_MODE:  rdata_d[0] = wprot_enable_q;
                OFS_WP_STAT:
                begin
                    rdata_d[0]                      = wprot_violation_q;
                    rdata_d[WP_SRC_LSB +: ADDR_W]   = wpsrc_q;
                end
                OFS_IRQ_EN, OFS_IRQ_DIS: rresp_d = RESP_OKAY;
                default: rresp_d = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mode_q   <= MODE_RST;
            mask_q   <= MASK_RST;
            wprot_enable_q   <= 1'b0;
            wprot_violation_q   <= 1'b0;
            wpsrc_q  <= '0;
            awr_q    <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
            arr_q    <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= '0;
            irq_q    <= 1'b0;
        end
        else
        begin
            mode_q   <= mode_d;
            mask_q   <= mask_d;
            wprot_enable_q   <= wprot_enable_d;
            wprot_violation_q   <= wprot_violation_d;
            wpsrc_q  <= wpsrc_d;
            awr_q    <= awr_d;
            bvalid_q <= bvalid_d;
            bresp_q  <= bresp_d;
            arr_q    <= arr_d;
            rvalid_q <= rvalid_d;
            rresp_q  <= rresp_d;
            rdata_q  <= rdata_d;
            irq_q    <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    assign axi_o.awready     = awr_q;
    assign axi_o.wready      = awr_q;
    assign axi_o.bresp       = bresp_q;
    assign axi_o.bvalid      = bvalid_q;
    assign axi_o.arready     = arr_q;
    assign axi_o.rdata       = rdata_q;
    assign axi_o.rresp       = rresp_q;
    assign axi_o.rvalid      = rvalid_q;
    assign pin_input_force_o = mode_q.capture_enable;
    assign dma_rx_req_o      = ready_q;
    assign dma_rx_data_o     = hold_q;
    assign irq_o             = irq_q;

endmodule : pci_capture_top
`default_nettype wire

// file: test/pci_capture_checker.sv
// concurrent checks on the capture block's bus, dma and pin-force ports
// assumes binding onto pci_capture_top, one clk_i domain
`timescale 1ns/1ps
`default_nettype none
module pci_capture_checker (
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    input  wire pci_pkg::pci_axi_req_s axi_i,
    input  wire pci_pkg::pci_axi_rsp_s axi_o,
    input  wire logic                  pin_input_force_o,
    input  wire logic                  rx_transfer_end_i,
    input  wire logic                  dma_rx_req_o,
    input  wire logic [31:0]           dma_rx_data_o,
    input  wire logic                  dma_rx_ack_i
);
    import pci_pkg::*;
    logic wr_take;
    logic rd_take;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////////////
    // bus handshake qualifiers
    assign wr_take = axi_i.awvalid && axi_o.awready;
    assign rd_take = axi_i.arvalid && axi_o.arready;
    ////////////////////////////////////////////////////////////////////////
    // register bus answers
    AST_WR_RESP: assert property (wr_take |=> axi_o.bvalid) else $error("no write response");
    AST_B_HOLD: assert property (axi_o.bvalid && !axi_i.bready |=> axi_o.bvalid && $stable(axi_o.bresp))
        else $error("write response dropped");
    AST_RD_RESP: assert property (rd_take |=> axi_o.rvalid) else $error("no read response");
    AST_R_HOLD: assert property (axi_o.rvalid && !axi_i.rready |=> axi_o.rvalid && $stable(axi_o.rdata))
        else $error("read data dropped");
    AST_SLVERR: assert property (rd_take && axi_i.araddr > OFS_WP_STAT |=> axi_o.rresp == RESP_SLVERR
        && axi_o.rdata == 32'h0) else $error("unmapped read not refused");
    ////////////////////////////////////////////////////////////////////////
    // capture path and dma side
    AST_FORCE_CAUSE: assert property ($rose(pin_input_force_o) |-> $past(wr_take) || $past(wr_take, 2))
        else $error("pins forced without a write");
    AST_NO_CAPTURE_OFF: assert property ($rose(dma_rx_req_o) |-> pin_input_force_o || $past(pin_input_force_o))
        else $error("word stored while disabled");
    AST_DATA_CAUSE: assert property ($changed(dma_rx_data_o) |-> dma_rx_req_o)
        else $error("holding word changed without ready");
    AST_READY_HOLD: assert property (dma_rx_req_o && !dma_rx_ack_i && !(rd_take && axi_i.araddr == OFS_HOLD)
        |=> dma_rx_req_o) else $error("ready lost without a read");
    AST_ACK_CLR: assert property (dma_rx_req_o && dma_rx_ack_i |=> !dma_rx_req_o || $changed(dma_rx_data_o))
        else $error("dma ack did not consume");
    AST_END_LIVE: assert property (rd_take && axi_i.araddr == OFS_STATUS
        |=> axi_o.rdata[ST_END] == $past(rx_transfer_end_i)) else $error("end flag not shown");
    ////////////////////////////////////////////////////////////////////////
    // main scenarios reached
    cover property ($rose(dma_rx_req_o));
    cover property (dma_rx_req_o && dma_rx_ack_i);
    cover property (rd_take && axi_i.araddr > OFS_WP_STAT);
endmodule : pci_capture_checker

bind pci_capture_top pci_capture_checker pci_capture_checker_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .axi_i(axi_i), .axi_o(axi_o), .pin_input_force_o(pin_input_force_o),
    .rx_transfer_end_i(rx_transfer_end_i), .dma_rx_req_o(dma_rx_req_o), .dma_rx_data_o(dma_rx_data_o),
    .dma_rx_ack_i(dma_rx_ack_i)
);
`default_nettype wire

// file: test/pci_sensor_model.sv
// sensor-side source: clock, byte bus and two data enables
// assumes the receiver samples on the rising sensor clock edge
`timescale 1ns/1ps
`default_nettype none
module pci_sensor_model #(
    parameter int HALF_NS = 100
) (
    output var logic       sensor_clk_in_o,
    output var logic [7:0] sensor_data_in_o,
    output var logic       data_valid_in_a_o,
    output var logic       data_valid_in_b_o
);
    ////////////////////////////////////////////////////////////////////////
    // idle levels: clock stands low outside frames
    initial
    begin
        sensor_clk_in_o   = 1'b0;
        sensor_data_in_o  = 8'h00;
        data_valid_in_a_o = 1'b0;
        data_valid_in_b_o = 1'b0;
    end

    // one sensor clock period; lines change on the falling edge
    task automatic send(input logic [7:0] d, input logic a, input logic b);
        sensor_data_in_o  = d;
        data_valid_in_a_o = a;
        data_valid_in_b_o = b;
        #(HALF_NS);
        sensor_clk_in_o = 1'b1;
        #(HALF_NS);
        sensor_clk_in_o   = 1'b0;
        sensor_data_in_o  = ~d; // stale value never repeats
        data_valid_in_a_o = ~a;
        data_valid_in_b_o = ~b;
    endtask : send
endmodule : pci_sensor_model
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the parallel capture block
// assumes AXI4-Lite tasks below and the sensor model as the pin source
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pci_pkg::*;
    logic         clk_i;
    logic         rst_b_i;
    pci_axi_req_s req;
    pci_axi_rsp_s rsp;
    logic         sclk, ena, enb, force_o, rx_end, rx_full, dreq, ack, irq;
    logic [7:0]   sdat;
    logic [31:0]  ddat, rv;
    logic [1:0]   rs;
    int           n_errors, checked;

    pci_capture_top pci_capture_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .axi_i(req), .axi_o(rsp),
        .sensor_clk_in_i(sclk), .sensor_data_in_i(sdat), .data_valid_in_a_i(ena), .data_valid_in_b_i(enb),
        .pin_input_force_o(force_o), .rx_transfer_end_i(rx_end), .rx_buffers_full_i(rx_full),
        .dma_rx_req_o(dreq), .dma_rx_data_o(ddat), .dma_rx_ack_i(ack), .irq_o(irq));
    pci_sensor_model pci_sensor_model_i (.sensor_clk_in_o(sclk), .sensor_data_in_o(sdat),
        .data_valid_in_a_o(ena), .data_valid_in_b_o(enb));

    ////////////////////////////////////////////////////////////////////////
    // 40 MHz clock and hang watchdog
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial
    begin
        #100us;
        n_errors++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////
    // compare, bus access and closing tasks
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req <= '{awaddr: a, awvalid: 1'b1, wdata: d, wstrb: 4'hF, wvalid: 1'b1, bready: 1'b1, default: '0};
        do @(negedge clk_i); while (rsp.awready !== 1'b1);
        @(posedge clk_i);
        req.awvalid <= 1'b0;
        req.wvalid  <= 1'b0;
        do @(negedge clk_i); while (rsp.bvalid !== 1'b1);
        rs = rsp.bresp;
        @(posedge clk_i);
        req.bready <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [7:0] a, input string nm, input logic [31:0] exp);
        @(posedge clk_i);
        req <= '{araddr: a, arvalid: 1'b1, rready: 1'b1, default: '0};
        do @(negedge clk_i); while (rsp.arready !== 1'b1);
        @(posedge clk_i);
        req.arvalid <= 1'b0;
        do @(negedge clk_i); while (rsp.rvalid !== 1'b1);
        rv = rsp.rdata;
        rs = rsp.rresp;
        @(posedge clk_i);
        req.rready <= 1'b0;
        chk(nm, rv, exp);
    endtask : rdc

    // lets a stored word land
    task automatic settle;
        repeat (8) @(posedge clk_i);
    endtask : settle

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////
    // test sequence
    initial
    begin
        req      = '0;
        ack      = 1'b0;
        rx_end   = 1'b0;
        rx_full  = 1'b0;
        rst_b_i  = 1'b0;
        n_errors = 0;
        checked  = 0;
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rdc(OFS_MODE, "mode", 32'h0);
        rdc(OFS_STATUS, "status", 32'h0);
        rdc(8'h20, "unmapped", 32'h0);
        chk("unmapped resp", rs, RESP_SLVERR);
        wr(8'h20, 32'h0);
        chk("unmapped wr", rs, RESP_SLVERR);
        chk("force", force_o, 1'b0);
        $display("test reset done");
        // 16-bit words, both enables required
        wr(OFS_IRQ_EN, 32'h1);
        wr(OFS_MODE, 32'h10);
        wr(OFS_MODE, 32'h11);
        chk("force", force_o, 1'b1);
        @(negedge clk_i);
        pci_sensor_model_i.send(8'h12, 1'b1, 1'b1);
        pci_sensor_model_i.send(8'hEE, 1'b1, 1'b0);
        pci_sensor_model_i.send(8'h77, 1'b0, 1'b1);
        pci_sensor_model_i.send(8'h34, 1'b1, 1'b1);
        settle();
        chk("ready", dreq, 1'b1);
        chk("irq", irq, 1'b1);
        rdc(OFS_HOLD, "hold16", 32'h3412);
        rdc(OFS_STATUS, "status", 32'h0);
        chk("irq", irq, 1'b0);
        $display("test packing done");
        // enables ignored, then overrun
        wr(OFS_MODE, 32'h10);
        wr(OFS_MODE, 32'h200);
        wr(OFS_MODE, 32'h201);
        @(negedge clk_i);
        pci_sensor_model_i.send(8'hA5, 1'b0, 1'b0);
        settle();
        rdc(OFS_HOLD, "hold8", 32'hA5);
        @(negedge clk_i);
        pci_sensor_model_i.send(8'h5A, 1'b0, 1'b0);
        pci_sensor_model_i.send(8'hC3, 1'b0, 1'b0);
        settle();
        rdc(OFS_STATUS, "overrun", 32'h3);
        rdc(OFS_STATUS, "ovr clear", 32'h1);
        rdc(OFS_HOLD, "newest", 32'hC3);
        $display("test overrun done");
        // half sampling both phases; five bytes leave a partial word in the even phase only
        wr(OFS_MODE, 32'h200);
        for (int f = 0; f < 2; f++)
        begin
            wr(OFS_MODE, 32'h610 | (f << 11));
            wr(OFS_MODE, 32'h611 | (f << 11));
            @(negedge clk_i);
            for (int i = 0; i < 5; i++)
                pci_sensor_model_i.send(8'h10 + i[7:0], 1'b0, 1'b0);
            settle();
            rdc(OFS_HOLD, "half", (f == 1) ? 32'h1311 : 32'h1210);
            wr(OFS_MODE, 32'h610 | (f << 11));
        end
        $display("test half sampling done");
        // dma consumer and status flags
        wr(OFS_IRQ_DIS, 32'h1);
        wr(OFS_IRQ_EN, 32'hC);
        wr(OFS_MODE, 32'h220);
        wr(OFS_MODE, 32'h221);
        rx_end  <= 1'b1;
        rx_full <= 1'b1;
        @(negedge clk_i);
        for (int i = 0; i < 4; i++)
            pci_sensor_model_i.send(8'h9C + i[7:0], 1'b1, 1'b0);
        settle();
        chk("irq", irq, 1'b1);
        chk("dma data", ddat, 32'h9F9E9D9C);
        rdc(OFS_STATUS, "dma flags", 32'hD);
        @(posedge clk_i);
        ack <= 1'b1;
        @(posedge clk_i);
        ack <= 1'b0;
        @(negedge clk_i);
        chk("dma req", dreq, 1'b0);
        wr(OFS_IRQ_DIS, 32'hC);
        @(negedge clk_i);
        chk("irq masked", irq, 1'b0);
        $display("test dma done");
        // write protection on the mode register
        wr(OFS_WP_MODE, 32'h1);
        wr(OFS_MODE, 32'h220);
        chk("wp resp", rs, RESP_OKAY);
        rdc(OFS_MODE, "mode kept", 32'h221);
        rdc(OFS_WP_STAT, "wp stat", 32'h1);
        rdc(OFS_WP_STAT, "wp clear", 32'h0);
        wr(OFS_WP_MODE, 32'h0);
        wr(OFS_MODE, 32'h220);
        chk("force", force_o, 1'b0);
        $display("test protection done");
        end_sim();
    end
endmodule : testbench
`default_nettype wire
